// ### logic/flash_pkg.sv
// shared constants for the serial flash erase/suspend link and its two ends
// assumes a 100 MHz system clock on both ends and a mode-0 serial link
package flash_pkg;
   // ***********************************************
   // opcodes
   // ***********************************************
   localparam logic [7:0] OP_ERASE_4K = 8'h20;
   localparam logic [7:0] OP_ERASE_32K = 8'h52;
   localparam logic [7:0] OP_ERASE_64K = 8'hD8;
   localparam logic [7:0] OP_CHIP_A = 8'h60;
   localparam logic [7:0] OP_CHIP_B = 8'hC7;
   localparam logic [7:0] OP_SUSPEND = 8'h75;
   localparam logic [7:0] OP_RESUME = 8'h7A;
   localparam logic [7:0] OP_PROGRAM = 8'h02;
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_STATUS_1 = 8'h05;
   localparam logic [7:0] OP_STATUS_2 = 8'h35;
   localparam logic [7:0] OP_SEC_ERASE = 8'h44;
   localparam logic [7:0] OP_SEC_PROG = 8'h42;
   localparam logic [7:0] OP_SEC_READ = 8'h48;
   localparam logic [7:0] OP_STATUS_WR = 8'h01;
   localparam logic [7:0] OP_VOL_WREN = 8'h50;
   localparam logic [7:0] OP_ID_JEDEC = 8'h9F;
   localparam logic [7:0] OP_ID = 8'h90;
   localparam logic [7:0] OP_SLEEP = 8'hB9;
   localparam logic [7:0] OP_WAKE = 8'hAB;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_READ_FAST = 8'h0B;
   localparam logic [7:0] OP_READ_DUAL = 8'h3B;
   localparam logic [7:0] OP_READ_DUAL_IO = 8'hBB;
   localparam logic [7:0] OP_READ_QUAD = 8'h6B;
   localparam logic [7:0] OP_READ_QUAD_IO = 8'hEB;
   localparam logic [7:0] OP_CONT_RESET = 8'hFF;
   // ***********************************************
   // frame, address and status layout
   // ***********************************************
   localparam logic [5:0] BITS_OPCODE = 6'h08;
   localparam logic [5:0] BITS_ADDR_END = 6'h20;
   localparam logic [5:0] BITS_FIRST_DATA = 6'h28;
   localparam logic [5:0] BITS_MAX = 6'h3F;
   localparam logic [23:0] MASK_4K = 24'h00_0FFF;
   localparam logic [23:0] MASK_32K = 24'h00_7FFF;
   localparam logic [23:0] MASK_64K = 24'h00_FFFF;
   localparam logic [23:0] MASK_PAGE = 24'h00_00FF;
   localparam logic [23:0] MASK_CHIP = 24'hFF_FFFF;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_WEL_BIT = 1;
   localparam int STAT_SUS_BIT = 7;
   localparam logic [7:0] BYTE_IDLE = 8'hFF;
   localparam logic [7:0] BYTE_UNDEFINED = 8'h00;
   // ***********************************************
   // timing
   // ***********************************************
   localparam int CLK_MHZ = 100;
   localparam int CLK_PERIOD_NS = 10;
   localparam int BLOCK_ERASE_TIME_US = 2000;
   localparam int CHIP_ERASE_TIME_US = 20000;
   localparam int PROGRAM_TIME_US = 500;
   localparam int SUSPEND_LATENCY_US = 20;
   localparam int BLOCK_ERASE_CYCLES_DEF = BLOCK_ERASE_TIME_US * CLK_MHZ;
   localparam int CHIP_ERASE_CYCLES_DEF = CHIP_ERASE_TIME_US * CLK_MHZ;
   localparam int PROGRAM_CYCLES_DEF = PROGRAM_TIME_US * CLK_MHZ;
   localparam int SUSPEND_LATENCY_CYCLES = SUSPEND_LATENCY_US * CLK_MHZ;
   localparam int SCLK_PERIOD_NS = 160;
   localparam logic [3:0] SCLK_HALF_CYCLES = 4'(SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS));
   // ***********************************************
   // host register map (word index)
   // ***********************************************
   localparam logic [1:0] REG_TX = 2'h0;
   localparam logic [1:0] REG_CTRL = 2'h1;
   localparam logic [1:0] REG_STATUS = 2'h2;
   localparam logic [1:0] REG_RX = 2'h3;
   // ***********************************************
   // types
   // ***********************************************
   typedef enum logic [2:0] {JOB_E4K, JOB_E32K, JOB_E64K, JOB_CHIP, JOB_PROG} job_t;
   typedef enum logic [3:0] {
      ENG_IDLE = 4'b0001,
      ENG_RUN = 4'b0010,
      ENG_HALT = 4'b0100,
      ENG_SUSP = 4'b1000
   } eng_state_t;
   typedef enum logic [5:0] {
      H_IDLE = 6'b000001,
      H_LEAD = 6'b000010,
      H_LOW = 6'b000100,
      H_HIGH = 6'b001000,
      H_TRAIL = 6'b010000,
      H_GAP = 6'b100000
   } host_state_t;
endpackage : flash_pkg

// ### logic/flash_link.sv
// serial link between the flash host end and the flash device end
// the data-out line is pulled high whenever the device does not drive it
interface flash_link;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso_d;
   logic miso_oe;
   logic miso;
   assign miso = miso_oe ? miso_d : 1'b1;
   modport dev(input sclk, input cs_n, input mosi, output miso_d, output miso_oe);
   modport host(output sclk, output cs_n, output mosi, input miso);
endinterface : flash_link

// ### logic/flash_erase_dev.sv
// device end: command intake, erase engine, suspend and write enable latch
// assumes link pins asynchronous to clk_i; protection decode and array live outside
//
// Chosen here: strobed register access and the placing of the registers.
module flash_erase_dev
   import flash_pkg::*;
#(
   parameter int unsigned BLOCK_ERASE_CYCLES = BLOCK_ERASE_CYCLES_DEF,
   parameter int unsigned CHIP_ERASE_CYCLES = CHIP_ERASE_CYCLES_DEF,
   parameter int unsigned PROGRAM_CYCLES = PROGRAM_CYCLES_DEF
) (
   input wire logic clk_i,
   input wire logic rst_i,
   flash_link.dev link,
   input wire logic protect_i,
   input wire logic [7:0] array_data_i,
   output logic [23:0] array_addr_o,
   output logic [23:0] erase_addr_o,
   output logic busy_o,
   output logic wel_o,
   output logic suspend_o,
   output logic read_undef_o
);
   // ***********************************************
   // decode helpers
   // ***********************************************
   function automatic logic [23:0] low_mask(input job_t j);
      case (j)
         JOB_E4K: low_mask = MASK_4K;
         JOB_E32K: low_mask = MASK_32K;
         JOB_E64K: low_mask = MASK_64K;
         JOB_PROG: low_mask = MASK_PAGE;
         default: low_mask = MASK_CHIP;
      endcase
   endfunction : low_mask

   function automatic logic is_read(input logic [7:0] op);
      is_read = (op == OP_READ) || (op == OP_READ_FAST) || (op == OP_READ_DUAL) ||
                (op == OP_READ_DUAL_IO) || (op == OP_READ_QUAD) || (op == OP_READ_QUAD_IO);
   endfunction : is_read

   function automatic logic open_in_suspend(input logic [7:0] op, input logic prog_susp);
      case (op)
         OP_RESUME, OP_WREN, OP_WRDI, OP_SEC_READ, OP_STATUS_1, OP_STATUS_2,
         OP_ID_JEDEC, OP_ID, OP_WAKE, OP_CONT_RESET: open_in_suspend = 1'b1;
         OP_PROGRAM: open_in_suspend = !prog_susp;
         default: open_in_suspend = is_read(op);
      endcase
   endfunction : open_in_suspend

   // ***********************************************
   // pin synchronisers: [0] feeds only [1]
   // ***********************************************
   logic [2:0] sclk_s;
   logic [2:0] cs_s;
   logic [1:0] mosi_s;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sclk_s <= 3'b000;
         cs_s <= 3'b111;
         mosi_s <= 2'b00;
      end else begin
         sclk_s <= {sclk_s[1:0], link.sclk};
         cs_s <= {cs_s[1:0], link.cs_n};
         mosi_s <= {mosi_s[0], link.mosi};
      end
   end

   logic sclk_rise;
   logic sclk_fall;
   logic cs_rise;
   assign sclk_rise = sclk_s[1] & ~sclk_s[2] & ~cs_s[1];
   assign sclk_fall = ~sclk_s[1] & sclk_s[2] & ~cs_s[1];
   assign cs_rise = cs_s[1] & ~cs_s[2];

   // ***********************************************
   // frame intake
   // ***********************************************
   logic [5:0] bitcnt_reg;
   logic [7:0] op_reg;
   logic [23:0] addr_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i || cs_s[1]) begin
         bitcnt_reg <= 6'h00;
      end else if (sclk_rise && bitcnt_reg != BITS_MAX) begin
         bitcnt_reg <= bitcnt_reg + 6'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         op_reg <= 8'h00;
         addr_reg <= 24'h00_0000;
      end else if (sclk_rise) begin
         if (bitcnt_reg < BITS_OPCODE) begin
            op_reg <= {op_reg[6:0], mosi_s[1]};
         end else if (bitcnt_reg < BITS_ADDR_END) begin
            addr_reg <= {addr_reg[22:0], mosi_s[1]};
         end
      end
   end

   // ***********************************************
   // erase engine and latches
   // ***********************************************
   eng_state_t state_reg;
   job_t job_reg;
   job_t sv_job_reg;
   logic [31:0] cnt_reg;
   logic [31:0] sv_cnt_reg;
   logic [23:0] sv_addr_reg;
   logic wel_reg;
   logic susp_reg;
   logic busy_reg;

   logic cmd_ok;
   logic bnd;
   logic has_addr;
   logic allowed;
   logic in_susp_blk;
   job_t new_job;
   assign cmd_ok = cs_rise && bitcnt_reg >= BITS_OPCODE;
   assign bnd = bitcnt_reg[2:0] == 3'd0;
   assign has_addr = bitcnt_reg >= BITS_ADDR_END;
   assign allowed = !susp_reg || open_in_suspend(op_reg, sv_job_reg == JOB_PROG);
   // erase block holds the target if it matches above the ignored field
   assign in_susp_blk = susp_reg && sv_job_reg != JOB_PROG &&
                        ((addr_reg ^ sv_addr_reg) & ~low_mask(sv_job_reg)) == 24'h00_0000;
   assign new_job = (op_reg == OP_ERASE_4K) ? JOB_E4K :
                    (op_reg == OP_ERASE_32K) ? JOB_E32K : JOB_E64K;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= ENG_IDLE;
         job_reg <= JOB_E4K;
         sv_job_reg <= JOB_E4K;
         cnt_reg <= 32'h0000_0000;
         sv_cnt_reg <= 32'h0000_0000;
         sv_addr_reg <= 24'h00_0000;
         erase_addr_o <= 24'h00_0000;
         wel_reg <= 1'b0;
         susp_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else begin
         case (state_reg)
            ENG_RUN: begin
               if (cnt_reg == 32'h0000_0000) begin
                  // a program run inside an erase suspend falls back to it
                  state_reg <= susp_reg ? ENG_SUSP : ENG_IDLE;
                  busy_reg <= 1'b0;
               end else begin
                  cnt_reg <= cnt_reg - 32'h0000_0001;
               end
            end
            ENG_HALT: begin
               if (cnt_reg == 32'h0000_0000) begin
                  state_reg <= ENG_SUSP;
                  susp_reg <= 1'b1;
                  busy_reg <= 1'b0;
               end else begin
                  cnt_reg <= cnt_reg - 32'h0000_0001;
               end
            end
            default: ;
         endcase
         if (cmd_ok && !busy_reg && allowed) begin
            case (op_reg)
               OP_WREN: if (bnd) wel_reg <= 1'b1;
               OP_WRDI: if (bnd) wel_reg <= 1'b0;
               OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K: begin
                  if (!bnd || !has_addr || protect_i) begin
                     wel_reg <= 1'b0;
                  end else if (wel_reg) begin
                     state_reg <= ENG_RUN;
                     busy_reg <= 1'b1;
                     wel_reg <= 1'b0;
                     job_reg <= new_job;
                     cnt_reg <= 32'(BLOCK_ERASE_CYCLES - 1);
                     erase_addr_o <= addr_reg & ~low_mask(new_job);
                  end
               end
               OP_CHIP_A, OP_CHIP_B: begin
                  if (!bnd || protect_i) begin
                     wel_reg <= 1'b0;
                  end else if (wel_reg) begin
                     state_reg <= ENG_RUN;
                     busy_reg <= 1'b1;
                     wel_reg <= 1'b0;
                     job_reg <= JOB_CHIP;
                     cnt_reg <= 32'(CHIP_ERASE_CYCLES - 1);
                     erase_addr_o <= 24'h00_0000;
                  end
               end
               OP_PROGRAM: begin
                  if (!bnd || bitcnt_reg < BITS_FIRST_DATA || protect_i || in_susp_blk) begin
                     wel_reg <= 1'b0;
                  end else if (wel_reg) begin
                     state_reg <= ENG_RUN;
                     busy_reg <= 1'b1;
                     wel_reg <= 1'b0;
                     job_reg <= JOB_PROG;
                     cnt_reg <= 32'(PROGRAM_CYCLES - 1);
                     erase_addr_o <= addr_reg & ~MASK_PAGE;
                  end
               end
               OP_RESUME: begin
                  if (bnd && susp_reg) begin
                     state_reg <= ENG_RUN;
                     busy_reg <= 1'b1;
                     susp_reg <= 1'b0;
                     job_reg <= sv_job_reg;
                     cnt_reg <= sv_cnt_reg;
                     erase_addr_o <= sv_addr_reg;
                  end
               end
               default: ;
            endcase
         end else if (cmd_ok && op_reg == OP_SUSPEND && bnd && state_reg == ENG_RUN &&
                      cnt_reg != 32'h0000_0000 && job_reg != JOB_CHIP &&
                      !(job_reg == JOB_PROG && susp_reg)) begin
            state_reg <= ENG_HALT;
            sv_job_reg <= job_reg;
            sv_cnt_reg <= cnt_reg;
            sv_addr_reg <= erase_addr_o;
            cnt_reg <= 32'(SUSPEND_LATENCY_CYCLES - 1);
         end
      end
   end

   // ***********************************************
   // data out: status and array bytes
   // ***********************************************
   logic [7:0] tx_reg;
   logic [7:0] status_byte;
   logic undef_now;
   logic [7:0] next_byte;
   assign status_byte = (8'(susp_reg) << STAT_SUS_BIT) | (8'(wel_reg) << STAT_WEL_BIT) |
                        (8'(busy_reg) << STAT_BUSY_BIT);
   assign undef_now = susp_reg && array_addr_o[23:16] == sv_addr_reg[23:16];

   always_comb begin
      next_byte = BYTE_IDLE;
      if (op_reg == OP_STATUS_1 || op_reg == OP_STATUS_2) begin
         next_byte = status_byte;
      end else if (is_read(op_reg) && bitcnt_reg >= BITS_ADDR_END) begin
         next_byte = undef_now ? BYTE_UNDEFINED : array_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_reg <= BYTE_IDLE;
         link.miso_d <= 1'b1;
         link.miso_oe <= 1'b0;
         array_addr_o <= 24'h00_0000;
         read_undef_o <= 1'b0;
      end else begin
         link.miso_oe <= ~cs_s[1];
         if (sclk_rise && bitcnt_reg == BITS_ADDR_END - 6'h01) begin
            array_addr_o <= {addr_reg[22:0], mosi_s[1]};
         end
         if (sclk_fall && bnd && bitcnt_reg != 6'h00) begin
            link.miso_d <= next_byte[7];
            tx_reg <= {next_byte[6:0], 1'b1};
            if (is_read(op_reg) && bitcnt_reg >= BITS_ADDR_END) begin
               // address walks on so a burst can run into and out of the held block
               array_addr_o <= array_addr_o + 24'h00_0001;
               read_undef_o <= undef_now;
            end
         end else if (sclk_fall) begin
            link.miso_d <= tx_reg[7];
            tx_reg <= {tx_reg[6:0], 1'b1};
         end
         if (cs_s[1]) begin
            read_undef_o <= 1'b0;
         end
      end
   end

   assign busy_o = busy_reg;
   assign wel_o = wel_reg;
   assign suspend_o = susp_reg;
endmodule : flash_erase_dev

// ### logic/flash_erase_host.sv
// host end: register-driven serial shifter that frames commands for the flash
// assumes the data-in pin is asynchronous; link clock made here by a divider
module flash_erase_host
   import flash_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   flash_link.host link
);
   host_state_t state_reg;
   logic [31:0] tx_data_reg;
   logic [5:0] nbits_reg;
   logic [31:0] sh_reg;
   logic [5:0] left_reg;
   logic [7:0] rx_reg;
   logic [3:0] div_reg;
   logic [1:0] miso_s;
   logic busy_reg;
   logic start;
   logic tick;

   // ***********************************************
   // register port
   // ***********************************************
   // a start while a frame runs is dropped, not queued
   assign start = wr_i && addr_i == REG_CTRL && state_reg == H_IDLE;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_data_reg <= 32'h0000_0000;
         nbits_reg <= 6'h00;
      end else if (wr_i && !busy_reg) begin
         if (addr_i == REG_TX) begin
            tx_data_reg <= wdata_i;
         end
         if (addr_i == REG_CTRL) begin
            nbits_reg <= wdata_i[5:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= 32'h0000_0000;
      end else if (rd_i) begin
         case (addr_i)
            REG_TX: rdata_o <= tx_data_reg;
            REG_CTRL: rdata_o <= {26'h000_0000, nbits_reg};
            REG_STATUS: rdata_o <= {31'h0000_0000, busy_reg};
            default: rdata_o <= {24'h00_0000, rx_reg};
         endcase
      end
   end

   // ***********************************************
   // half-period enable and data-in synchroniser
   // ***********************************************
   always_ff @(posedge clk_i) begin
      if (rst_i || state_reg == H_IDLE || tick) begin
         div_reg <= 4'h0;
      end else begin
         div_reg <= div_reg + 4'h1;
      end
   end
   assign tick = div_reg == SCLK_HALF_CYCLES - 4'h1;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         miso_s <= 2'b11;
      end else begin
         miso_s <= {miso_s[0], link.miso};
      end
   end

   // ***********************************************
   // frame sequencer, mode 0
   // ***********************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= H_IDLE;
         link.sclk <= 1'b0;
         link.cs_n <= 1'b1;
         link.mosi <= 1'b0;
         sh_reg <= 32'h0000_0000;
         left_reg <= 6'h00;
         rx_reg <= 8'h00;
         busy_reg <= 1'b0;
      end else begin
         case (state_reg)
            H_IDLE: begin
               if (start) begin
                  state_reg <= H_LEAD;
                  link.cs_n <= 1'b0;
                  busy_reg <= 1'b1;
                  sh_reg <= tx_data_reg;
                  left_reg <= wdata_i[5:0];
               end
            end
            H_LEAD, H_HIGH: begin
               if (tick) begin
                  link.sclk <= 1'b0;
                  if (left_reg == 6'h00) begin
                     state_reg <= H_TRAIL;
                  end else begin
                     // opcode then address, most significant bit first
                     state_reg <= H_LOW;
                     link.mosi <= sh_reg[31];
                     sh_reg <= {sh_reg[30:0], 1'b0};
                  end
               end
            end
            H_LOW: begin
               if (tick) begin
                  state_reg <= H_HIGH;
                  link.sclk <= 1'b1;
                  rx_reg <= {rx_reg[6:0], miso_s[1]};
                  left_reg <= left_reg - 6'h01;
               end
            end
            H_TRAIL: begin
               if (tick) begin
                  state_reg <= H_GAP;
                  link.cs_n <= 1'b1;
                  link.mosi <= 1'b0;
               end
            end
            H_GAP: begin
               if (tick) begin
                  state_reg <= H_IDLE;
                  busy_reg <= 1'b0;
               end
            end
            default: state_reg <= H_IDLE;
         endcase
      end
   end
endmodule : flash_erase_host

// ### dv/flash_erase_assertions.sv
// checker on the link pins and device flags, beside the joined link
// assumes one clock domain with a synchronous active-high reset
module flash_erase_assertions (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic busy_o,
   input wire logic wel_o,
   input wire logic suspend_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // ****
   // framing and flags
   // ****
   property p_sclk_idle; cs_n |-> !sclk; endproperty
   a_sclk_idle: assert property (p_sclk_idle) else $error("clock runs outside frame");
   property p_mosi_hold; sclk |-> $stable(mosi); endproperty
   a_mosi_hold: assert property (p_mosi_hold) else $error("data moved while clock high");
   property p_busy_start; $rose(busy_o) |-> cs_n && $past(cs_n, 3); endproperty
   a_busy_start: assert property (p_busy_start) else $error("job started inside frame");
   property p_wel_change; $changed(wel_o) |-> cs_n && $past(cs_n, 2); endproperty
   a_wel_change: assert property (p_wel_change) else $error("latch moved inside frame");
   property p_wel_clear; $rose(busy_o) && !$fell(suspend_o) |-> !wel_o; endproperty
   a_wel_clear: assert property (p_wel_clear) else $error("latch kept at job start");
   property p_busy_hold; $rose(busy_o) && !$fell(suspend_o) |=> busy_o [*8]; endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
   property p_sus_ready; $rose(suspend_o) |-> $fell(busy_o); endproperty
   a_sus_ready: assert property (p_sus_ready) else $error("suspend without ready");
   property p_resume; $fell(suspend_o) |-> $rose(busy_o) && cs_n; endproperty
   a_resume: assert property (p_resume) else $error("resume without busy");
   c_erase: cover property ($rose(busy_o));
   c_suspend: cover property ($rose(suspend_o));
   c_abort: cover property ($fell(wel_o) && !busy_o);
endmodule : flash_erase_assertions

// ### dv/spi_flash_erase_suspend_control_bench.sv
// bench: host and device ends on one link, driven via host registers
// assumes short erase counts; suspend latency stays at 2000 cycles
module spi_flash_erase_suspend_control_bench
   import flash_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, protect_i = 1'b0;
   logic [1:0] addr_i = 2'h0;
   logic [31:0] wdata_i = 32'h0000_0000;
   logic [31:0] rdata_o;
   logic [23:0] erase_addr_o, array_addr_o, fl;
   logic busy_o, wel_o, suspend_o, read_undef_o;
   logic undef_seen = 1'b0;
   int miscompares = 0, num_checks = 0;
   assign fl = {21'h00_0000, busy_o, wel_o, suspend_o};
   always #5 clk_i = ~clk_i;
   // sticky: the undefined-read flag only stands while the frame is open
   always @(posedge clk_i) undef_seen <= undef_seen | read_undef_o;
   flash_link flash_link_inst ();
   flash_erase_host flash_erase_host_inst (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .link(flash_link_inst));
   // program outlasts a suspend frame so a nested suspend lands mid-program
   flash_erase_dev #(.BLOCK_ERASE_CYCLES(1000), .CHIP_ERASE_CYCLES(600), .PROGRAM_CYCLES(400))
      flash_erase_dev_inst (.clk_i, .rst_i, .link(flash_link_inst), .protect_i, .array_data_i(8'h5A),
      .array_addr_o, .erase_addr_o, .busy_o, .wel_o, .suspend_o, .read_undef_o);
   flash_erase_assertions flash_erase_assertions_inst (.clk_i, .rst_i, .sclk(flash_link_inst.sclk),
      .cs_n(flash_link_inst.cs_n), .mosi(flash_link_inst.mosi), .busy_o, .wel_o, .suspend_o);
   // ****
   // bus and checks
   // ****
   task automatic wr(input logic [1:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [1:0] a);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
   endtask : rd
   // bounded poll of host busy; margin lets the device act on cs rise
   task automatic send(input logic [7:0] op, input logic [23:0] a, input logic [5:0] n);
      wr(REG_TX, {op, a});
      wr(REG_CTRL, {26'h000_0000, n});
      for (int k = 0; k < 2000 && (k == 0 || rdata_o[0] !== 1'b0); k++) rd(REG_STATUS);
      chk(24'(rdata_o[0]), 24'h00_0000);
      repeat (6) @(posedge clk_i);
   endtask : send
   task automatic idle();
      for (int k = 0; k < 3000 && busy_o !== 1'b0; k++) @(posedge clk_i);
   endtask : idle
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
         miscompares++;
      end
   endtask : chk
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run
   // ****
   // scenarios
   // ****
   task automatic t_abort();
      logic [7:0] op[5] = '{OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K, OP_CHIP_A, OP_CHIP_B};
      logic [5:0] n[5] = '{6'h1F, 6'h18, 6'h20, 6'h08, 6'h0C};
      send(OP_ERASE_4K, 24'h01_0000, 6'h20);
      chk(fl, 24'h00_0000);
      for (int i = 0; i < 5; i++) begin
         send(OP_WREN, 24'h00_0000, 6'h08);
         chk(fl, 24'h00_0002);
         protect_i <= (i == 2 || i == 3);
         send(op[i], 24'h05_4321, n[i]);
         chk(fl, 24'h00_0000);
      end
      protect_i <= 1'b0;
   endtask : t_abort
   task automatic t_erase();
      logic [7:0] op[5] = '{OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K, OP_CHIP_A, OP_CHIP_B};
      logic [23:0] m[5] = '{MASK_4K, MASK_32K, MASK_64K, MASK_CHIP, MASK_CHIP};
      for (int i = 0; i < 5; i++) begin
         send(OP_WREN, 24'h00_0000, 6'h08);
         send(op[i], 24'h1A_BCDE, i < 3 ? 6'h20 + 6'(8 * i) : 6'h10);
         chk(fl, 24'h00_0004);
         chk(erase_addr_o, 24'h1A_BCDE & ~m[i]);
         if (i > 2) begin
            send(OP_SUSPEND, 24'h00_0000, 6'h08);
            chk(fl, 24'h00_0004);
         end
         idle();
         chk(fl, 24'h00_0000);
      end
   endtask : t_erase
   // erase suspended, latch set again by WREN, then refused opcodes must not touch it
   task automatic t_suspend();
      logic [7:0] op[8] = '{OP_ERASE_4K, OP_CHIP_A, OP_SUSPEND, OP_SEC_ERASE, OP_SEC_PROG, OP_STATUS_WR,
         OP_VOL_WREN, OP_SLEEP};
      send(OP_WREN, 24'h00_0000, 6'h08);
      send(OP_ERASE_4K, 24'h02_0000, 6'h20);
      send(OP_SUSPEND, 24'h00_0000, 6'h08);
      idle();
      chk(fl, 24'h00_0001);
      send(OP_WREN, 24'h00_0000, 6'h08);
      for (int i = 0; i < 8; i++) begin
         send(op[i], 24'h30_0000, 6'h20);
         chk(fl, 24'h00_0003);
      end
      send(OP_WRDI, 24'h00_0000, 6'h08);
      chk(fl, 24'h00_0001);
      send(OP_WREN, 24'h00_0000, 6'h08);
      send(OP_PROGRAM, 24'h02_0100, 6'h28);
      chk(fl, 24'h00_0001);
      send(OP_WREN, 24'h00_0000, 6'h08);
      send(OP_PROGRAM, 24'h04_0100, 6'h28);
      chk(fl, 24'h00_0005);
      chk(erase_addr_o, 24'h04_0100);
      send(OP_SUSPEND, 24'h00_0000, 6'h08);
      chk(fl, 24'h00_0005);
      idle();
      chk(fl, 24'h00_0001);
      send(OP_READ, 24'h05_0010, 6'h28);
      rd(REG_RX);
      chk(rdata_o[23:0], 24'h00_005A);
      chk(24'(undef_seen), 24'h00_0000);
      send(OP_READ, 24'h02_0010, 6'h28);
      rd(REG_RX);
      chk(rdata_o[23:0], {16'h0000, BYTE_UNDEFINED});
      chk(24'(undef_seen), 24'h00_0001);
      chk(array_addr_o, 24'h02_0012);
      send(OP_RESUME, 24'h00_0000, 6'h08);
      chk(fl, 24'h00_0004);
      idle();
      chk(fl, 24'h00_0000);
   endtask : t_suspend
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_abort();
      t_erase();
      t_suspend();
      complete_run();
   end
   initial begin
      #1_000_000;
      miscompares++;
      complete_run();
   end
endmodule : spi_flash_erase_suspend_control_bench
